// ==== bench/pps_host_model.sv ====
// Serial master model that loads 32-bit words over the three-wire port
module pps_host_model
(
   input wire logic clk_sys_i, // System clock, paces the link
   output logic ser_clk_o, // Serial clock, still outside frames
   output logic ser_data_o, // Serial data
   output logic latch_strobe_o // Latch strobe
);
   timeunit 1ns;
   timeprecision 1ps;

   // ----------------------------------------
   // Idle levels
   // ----------------------------------------
   initial
   begin
      ser_clk_o = 1'b0; // Clock parks low between words
      ser_data_o = 1'b0;
      latch_strobe_o = 1'b0;
   end

   // ----------------------------------------
   // Word transfer, 160 ns per bit
   // ----------------------------------------
   // Four bytes, top byte and top bit first, data set well before the rise
   task automatic send_word(input logic [31:0] w);
      @(posedge clk_sys_i);
      latch_strobe_o <= 1'b0;
      for (int b = 31; b >= 0; b--)
      begin
         @(posedge clk_sys_i);
         ser_data_o <= w[b];
         repeat (2) @(posedge clk_sys_i);
         ser_clk_o <= 1'b1;
         repeat (4) @(posedge clk_sys_i);
         ser_clk_o <= 1'b0;
         repeat (1) @(posedge clk_sys_i);
      end
      @(posedge clk_sys_i);
      latch_strobe_o <= 1'b1;
      // Released data is not left showing the last bit
      ser_data_o <= ~w[0];
      repeat (4) @(posedge clk_sys_i);
   endtask
endmodule

// ==== bench/tb_top.sv ====
// Self-checking bench for the serial loader and resync timer
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   // ----------------------------------------
   // Clock, reset and pins
   // ----------------------------------------
   logic clk_sys_i = 1'b0; // 50 MHz
   logic sys_rst_i = 1'b1; // Held at start
   logic [2:0] ref_cnt = 3'h0; // Reference divider, 8 cycles a period
   logic ref_clk = 1'b0; // Phase detector reference
   logic ser_clk, ser_data, strobe; // Driven by the host model
   logic sync_pulse_o, phase_realign_o, fast_lock_o, resync_en_o;
   logic [11:0] phase_word_o, sdm_seed_o;
   logic [1:0] out_power_o;
   logic exp_q[$]; // Expected realign flag per sync pulse
   int err_count = 0;
   int n_checks = 0;
   int seed = 52;

   initial forever #10 clk_sys_i = ~clk_sys_i;

   // Reference runs free, so tick spacing is exact in system cycles
   always @(posedge clk_sys_i)
   begin
      ref_cnt <= ref_cnt + 3'h1;
      ref_clk <= ref_cnt[2];
   end

   pps_host_model pps_host_model_i (.clk_sys_i(clk_sys_i), .ser_clk_o(ser_clk),
      .ser_data_o(ser_data), .latch_strobe_o(strobe));

   pps_top pps_top_i (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .ser_clk_i(ser_clk),
      .ser_data_i(ser_data), .latch_strobe_i(strobe), .phase_detector_ref_i(ref_clk),
      .sync_pulse_o(sync_pulse_o), .phase_realign_o(phase_realign_o),
      .fast_lock_o(fast_lock_o), .resync_en_o(resync_en_o), .phase_word_o(phase_word_o),
      .sdm_seed_o(sdm_seed_o), .out_power_o(out_power_o));

   // ----------------------------------------
   // Compare tasks and closing report
   // ----------------------------------------
   task automatic check_field(input string nm, input logic [11:0] e, input logic [11:0] g);
      n_checks++;
      if (g !== e)
      begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic check_pulse(input logic e, input logic g);
      n_checks++;
      if (g !== e)
      begin
         err_count++;
         $display("[FAIL] phase_realign_o expected %b seen %b", e, g);
      end
   endtask

   task automatic check_span(input string nm, input int lo, input int hi, input int g);
      n_checks++;
      if (g < lo || g > hi)
      begin
         err_count++;
         $display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
      end
   endtask

   task automatic tally_and_finish;
      if (err_count == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // ----------------------------------------
   // Pulse watcher
   // ----------------------------------------
   // Each sync pulse takes the oldest note; with none noted no realign is due
   always @(negedge clk_sys_i)
   begin
      if (!sys_rst_i && sync_pulse_o === 1'b1)
         check_pulse(exp_q.size() > 0 ? exp_q.pop_front() : 1'b0, phase_realign_o);
      else if (phase_realign_o !== 1'b0 && !sys_rst_i)
         check_pulse(1'b0, phase_realign_o);
   end

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Commit lands a few cycles after the strobe; eight cycles covers it
   task automatic wr(input logic [31:0] w);
      pps_host_model_i.send_word(w);
      repeat (8) @(negedge clk_sys_i);
   endtask

   // Cycles until the next sync pulse, bounded
   task automatic wait_sync(output int n);
      n = 0;
      do
      begin
         @(negedge clk_sys_i);
         n++;
      end
      while (sync_pulse_o !== 1'b1 && n < 2000);
      if (n >= 2000)
      begin
         check_span("sync wait", 0, 1999, n);
         tally_and_finish();
      end
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      logic [31:0] w;
      logic [11:0] p;
      int n;
      repeat (4) @(posedge clk_sys_i);
      sys_rst_i <= 1'b0;
      @(negedge clk_sys_i);
      check_field("out_power_o", 12'h0, {10'h0, out_power_o});
      check_field("resync_en_o", 12'h0, {11'h0, resync_en_o});
      // Every power code, random filler elsewhere
      for (int i = 0; i < 4; i++)
      begin
         w = $random(seed);
         w[4:0] = {i[1:0], 3'h4};
         wr(w);
         check_field("out_power_o", 12'(i), {10'h0, out_power_o});
      end
      // Undefined destinations leave the power field alone
      wr(32'h0000_0007);
      wr(32'hffff_fff6);
      check_field("out_power_o", 12'h3, {10'h0, out_power_o});
      // Phase word with modulus 3, then dither on and off
      p = $random(seed);
      wr({5'h0, p, 12'h003, 3'h1});
      check_field("phase_word_o", p, phase_word_o);
      check_field("sdm_seed_o", p, sdm_seed_o);
      wr(32'h2000_0002);
      check_field("sdm_seed_o", 12'h0, sdm_seed_o);
      wr(32'h0000_0002);
      check_field("sdm_seed_o", p, sdm_seed_o);
      // Fast lock for three reference ticks
      wr({15'h0, 2'b01, 12'h003, 3'h3});
      wr(32'h0000_0000);
      check_field("fast_lock_o", 12'h1, {11'h0, fast_lock_o});
      repeat (40) @(negedge clk_sys_i);
      check_field("fast_lock_o", 12'h0, {11'h0, fast_lock_o});
      // Resync, divider 2 by modulus 3 is 48 cycles
      wr({15'h0, 2'b10, 12'h002, 3'h3});
      check_field("resync_en_o", 12'h1, {11'h0, resync_en_o});
      wr(32'h0000_0000);
      exp_q.push_back(1'b0);
      exp_q.push_back(1'b1);
      wait_sync(n);
      wait_sync(n);
      check_span("sync spacing", 48, 48, n);
      wait_sync(n);
      check_span("sync spacing", 48, 48, n);
      // Divider 3 gives 72 cycles; a new frequency word restarts the count
      wr({15'h0, 2'b10, 12'h003, 3'h3});
      w = $random(seed);
      w[2:0] = 3'h0;
      wr(w);
      exp_q.push_back(1'b0);
      exp_q.push_back(1'b1);
      wait_sync(n);
      check_span("first sync", 50, 72, n);
      wait_sync(n);
      check_span("sync spacing", 72, 72, n);
      wait_sync(n);
      wr(32'h0000_0003);
      check_field("resync_en_o", 12'h0, {11'h0, resync_en_o});
      tally_and_finish();
   end
endmodule

// ==== core/pps_defines.svh ====
// Bit positions, register indices and reset values for the serial load and resync block
`ifndef PPS_DEFINES_SVH
`define PPS_DEFINES_SVH

// ----------------------------------------
// Word layout and destination decode
// ----------------------------------------
`define PPS_WORD_W 32
`define PPS_ADDR_HI 2
`define PPS_ADDR_LO 0
`define PPS_NUM_REGS 6
`define PPS_IDX_FREQ 3'h0
`define PPS_IDX_MOD 3'h1
`define PPS_IDX_DITH 3'h2
`define PPS_IDX_DIV 3'h3
`define PPS_IDX_PWR 3'h4
`define PPS_REG_RST 32'h0000_0000

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PPS_CNT_W 12
`define PPS_MODE_HI 16
`define PPS_MODE_LO 15
`define PPS_MODE_RESYNC 2'h2
`define PPS_MODE_FASTLOCK 2'h1
`define PPS_DIV_HI 14
`define PPS_DIV_LO 3
`define PPS_MOD_HI 14
`define PPS_MOD_LO 3
`define PPS_PHASE_HI 26
`define PPS_PHASE_LO 15
`define PPS_DITHER_BIT 29
`define PPS_PWR_HI 4
`define PPS_PWR_LO 3

`endif

// ==== core/pps_pkg.sv ====
// Types shared by the serial load and resync block
package pps_pkg;
   // Progress of phase realignment after a frequency commit
   typedef enum logic [1:0] {PPS_RS_IDLE, PPS_RS_FIRST, PPS_RS_SECOND} pps_realign_t;
endpackage

// ==== core/pps_tick_cnt.sv ====
// Wrapping tick counter with load-free clear, used for the sync and fast-lock timers
`include "pps_defines.svh"
module pps_tick_cnt
(
   input wire logic clk_sys_i, // System clock
   input wire logic sys_rst_i, // Async reset, high
   input wire logic clr_i, // Restart count at zero
   input wire logic en_i, // Count one tick
   input wire logic [`PPS_CNT_W-1:0] limit_i, // Ticks per wrap, zero acts as one
   output logic wrap_o, // High on the tick that ends a span
   output logic [`PPS_CNT_W-1:0] count_o // Current count
);
   logic [`PPS_CNT_W-1:0] last; // Terminal count

   // ----------------------------------------
   // Terminal value and wrap
   // ----------------------------------------
   // Zero limit would otherwise wrap only after 4096 ticks, so it is folded onto one
   assign last = (limit_i == 12'h000) ? 12'h000 : limit_i - 12'h001;
   // Clear wins over the tick so a restart never emits a stray wrap
   assign wrap_o = en_i & ~clr_i & (count_o == last);

   // Count register
   always_ff @(posedge clk_sys_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         count_o <= 12'h000;
      else if (clr_i)
         count_o <= 12'h000;
      else if (wrap_o)
         count_o <= 12'h000;
      else if (en_i)
         count_o <= count_o + 12'h001;
   end
endmodule

// ==== core/pps_top.sv ====
// Serial word loader with phase resync timer, fast-lock timer and phase/power fields
//
// Overview of operation
// - Shift one data bit per rising serial clock while the strobe is low
// - Strobe rise commits 32 shifted bits to latch
// - Mode field pattern 1,0 enables resync
// - Sync pulse every divider times modulus periods
// - Divider taken from bits 14 to 3
// - Modulus taken from second register bits 14:3
// - Realign on second sync after commit
// - Phase word sets output phase steps
// - Dither off seeds modulator with phase word
// - Output power from fifth register bits 4:3
// - Mode pattern 0,1 runs fast-lock timer
`include "pps_defines.svh"
module pps_top
(
   input wire logic clk_sys_i, // 50 MHz system clock
   input wire logic sys_rst_i, // Async reset, high
   input wire logic ser_clk_i, // Serial clock pin
   input wire logic ser_data_i, // Serial data pin
   input wire logic latch_strobe_i, // Latch strobe pin
   input wire logic phase_detector_ref_i, // Phase detector reference clock pin
   output logic sync_pulse_o, // One-cycle sync pulse
   output logic phase_realign_o, // One-cycle realign command
   output logic fast_lock_o, // Wide bandwidth active
   output logic resync_en_o, // Resync mode selected
   output logic [11:0] phase_word_o, // Output phase word
   output logic [11:0] sdm_seed_o, // Sigma delta modulator seed
   output logic [1:0] out_power_o // Output power select
);
   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [3:0] pin_q1; // First stages, read by second stages only
   logic [3:0] pin_q2; // Second stages
   logic [3:0] pin_q3; // Delayed copy for edge finding

   always_ff @(posedge clk_sys_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         pin_q1 <= 4'h0;
         pin_q2 <= 4'h0;
         pin_q3 <= 4'h0;
      end
      else
      begin
         pin_q1 <= {phase_detector_ref_i, latch_strobe_i, ser_data_i, ser_clk_i};
         pin_q2 <= pin_q1;
         pin_q3 <= pin_q2;
      end
   end

   logic sclk_rise; // Serial clock rising edge
   logic strobe_rise; // Strobe rising edge
   logic pd_tick; // One phase detector period
   assign sclk_rise = pin_q2[0] & ~pin_q3[0];
   assign strobe_rise = pin_q2[2] & ~pin_q3[2];
   assign pd_tick = pin_q2[3] & ~pin_q3[3];

   // ----------------------------------------
   // Shift register and latches
   // ----------------------------------------
   logic [31:0] shift_reg; // Incoming word
   logic [31:0] ctrl_reg [`PPS_NUM_REGS]; // Committed latches
   logic [2:0] dest; // Destination of the shifted word
   logic dest_ok; // Destination is defined
   logic freq_commit; // Frequency word committed
   assign dest = shift_reg[`PPS_ADDR_HI:`PPS_ADDR_LO];
   assign dest_ok = (dest < 3'(`PPS_NUM_REGS));
   assign freq_commit = strobe_rise & (dest == `PPS_IDX_FREQ);

   // Shift only while the strobe is low, first bit lands at the top
   always_ff @(posedge clk_sys_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         shift_reg <= 32'h0000_0000;
      else if (sclk_rise & ~pin_q2[2])
         shift_reg <= {shift_reg[30:0], pin_q2[1]};
   end

   // Commit on strobe rise; undefined destinations leave every latch alone
   always_ff @(posedge clk_sys_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         for (int i = 0; i < `PPS_NUM_REGS; i++)
            ctrl_reg[i] <= `PPS_REG_RST;
      end
      else if (strobe_rise & dest_ok)
         ctrl_reg[dest] <= shift_reg;
   end

   // ----------------------------------------
   // Field decode
   // ----------------------------------------
   logic [1:0] mode; // Resync or fast-lock select
   logic [11:0] clk_div; // Interval divider
   logic [11:0] frac_mod; // Fractional modulus
   logic [11:0] phase_word; // Programmed phase
   logic resync_on; // Resync mode active
   assign mode = ctrl_reg[`PPS_IDX_DIV][`PPS_MODE_HI:`PPS_MODE_LO];
   assign clk_div = ctrl_reg[`PPS_IDX_DIV][`PPS_DIV_HI:`PPS_DIV_LO];
   assign frac_mod = ctrl_reg[`PPS_IDX_MOD][`PPS_MOD_HI:`PPS_MOD_LO];
   assign phase_word = ctrl_reg[`PPS_IDX_MOD][`PPS_PHASE_HI:`PPS_PHASE_LO];
   assign resync_on = (mode == `PPS_MODE_RESYNC);

   // ----------------------------------------
   // Sync interval timer
   // ----------------------------------------
   // Two cascaded counters avoid a 24-bit product in the datapath
   logic restart; // Clear the sync timer
   logic mod_wrap; // One modulus worth of periods
   logic sync_evt; // Interval complete
   assign restart = freq_commit | ~resync_on;

   pps_tick_cnt u_mod_cnt
   (
      .clk_sys_i(clk_sys_i),
      .sys_rst_i(sys_rst_i),
      .clr_i(restart),
      .en_i(pd_tick & resync_on),
      .limit_i(frac_mod),
      .wrap_o(mod_wrap),
      .count_o()
   );

   pps_tick_cnt u_div_cnt
   (
      .clk_sys_i(clk_sys_i),
      .sys_rst_i(sys_rst_i),
      .clr_i(restart),
      .en_i(mod_wrap),
      .limit_i(clk_div),
      .wrap_o(sync_evt),
      .count_o()
   );

   // Realign tracker: first pulse after commit is skipped
   pps_pkg::pps_realign_t rs_state; // Realign progress
   always_ff @(posedge clk_sys_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         rs_state <= pps_pkg::PPS_RS_IDLE;
      else if (~resync_on)
         rs_state <= pps_pkg::PPS_RS_IDLE;
      else if (freq_commit)
         rs_state <= pps_pkg::PPS_RS_FIRST;
      else if (sync_evt)
      begin
         unique case (rs_state)
            pps_pkg::PPS_RS_IDLE: rs_state <= pps_pkg::PPS_RS_IDLE;
            pps_pkg::PPS_RS_FIRST: rs_state <= pps_pkg::PPS_RS_SECOND;
            pps_pkg::PPS_RS_SECOND: rs_state <= pps_pkg::PPS_RS_IDLE;
         endcase
      end
   end

   // Registered pulses
   always_ff @(posedge clk_sys_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         sync_pulse_o <= 1'b0;
         phase_realign_o <= 1'b0;
      end
      else
      begin
         sync_pulse_o <= sync_evt;
         phase_realign_o <= sync_evt & ~freq_commit & (rs_state == pps_pkg::PPS_RS_SECOND);
      end
   end

   // ----------------------------------------
   // Fast-lock timer
   // ----------------------------------------
   logic fl_end; // Wide bandwidth span over
   pps_tick_cnt u_fl_cnt
   (
      .clk_sys_i(clk_sys_i),
      .sys_rst_i(sys_rst_i),
      .clr_i(freq_commit | ~fast_lock_o),
      .en_i(pd_tick & fast_lock_o),
      .limit_i(clk_div),
      .wrap_o(fl_end),
      .count_o()
   );

   // New frequency in fast-lock mode opens the wide bandwidth window
   always_ff @(posedge clk_sys_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         fast_lock_o <= 1'b0;
      else if (freq_commit & (mode == `PPS_MODE_FASTLOCK))
         fast_lock_o <= 1'b1;
      else if (fl_end | (mode != `PPS_MODE_FASTLOCK))
         fast_lock_o <= 1'b0;
   end

   // ----------------------------------------
   // Phase, seed and power outputs
   // ----------------------------------------
   always_ff @(posedge clk_sys_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         resync_en_o <= 1'b0;
         phase_word_o <= 12'h000;
         sdm_seed_o <= 12'h000;
         out_power_o <= 2'h0;
      end
      else
      begin
         resync_en_o <= resync_on;
         phase_word_o <= phase_word;
         // With dither on the seed is unused, so it is parked at zero
         sdm_seed_o <= ctrl_reg[`PPS_IDX_DITH][`PPS_DITHER_BIT] ? 12'h000 : phase_word;
         out_power_o <= ctrl_reg[`PPS_IDX_PWR][`PPS_PWR_HI:`PPS_PWR_LO];
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i);

   logic [23:0] h_ticks; // Periods since last sync or restart
   logic h_dirty; // Divider or modulus changed mid-span
   logic [1:0] h_syncs; // Syncs since last commit, 3 when not armed
   logic [11:0] h_fl; // Periods spent in fast lock
   always_ff @(posedge clk_sys_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         h_ticks <= 24'h00_0000;
         h_dirty <= 1'b0;
         h_syncs <= 2'h3;
         h_fl <= 12'h000;
      end
      else
      begin
         if (restart | sync_evt)
            h_ticks <= 24'h00_0000;
         else if (pd_tick)
            h_ticks <= h_ticks + 24'h00_0001;
         if (restart | sync_evt)
            h_dirty <= 1'b0;
         else if (strobe_rise & ((dest == `PPS_IDX_MOD) | (dest == `PPS_IDX_DIV)))
            h_dirty <= 1'b1;
         // Leaving resync drops the tracker too, so parked at 3 no realign is due
         if (~resync_on)
            h_syncs <= 2'h3;
         else if (freq_commit)
            h_syncs <= 2'h0;
         else if (sync_evt & (h_syncs != 2'h3))
            h_syncs <= h_syncs + 2'h1;
         if (~fast_lock_o | freq_commit)
            h_fl <= 12'h000;
         else if (pd_tick)
            h_fl <= h_fl + 12'h001;
      end
   end

   sequence s_first_sync;
      sync_evt && (h_syncs == 2'h0) && !freq_commit;
   endsequence
   sequence s_second_sync;
      sync_evt && (h_syncs == 2'h1) && !freq_commit && resync_on;
   endsequence

   a_shift_msb_first: assert property (sclk_rise && !pin_q2[2] |=> shift_reg[0] == $past(pin_q2[1]) && shift_reg[31:1] == $past(shift_reg[30:0])) else $error("shift wrong");
   a_commit_word: assert property (strobe_rise && dest_ok |=> ctrl_reg[$past(dest)] == $past(shift_reg)) else $error("latch not loaded");
   a_undef_dest: assert property (strobe_rise && !dest_ok |=> $stable(ctrl_reg[0]) && $stable(ctrl_reg[3])) else $error("undefined latch written");
   a_resync_mode: assert property (##1 resync_en_o == $past(mode == 2'h2)) else $error("resync enable wrong");
   a_sync_spacing: assert property (sync_evt && !h_dirty |-> (h_ticks + 24'h00_0001) == ({12'h000, (clk_div == 12'h000) ? 12'h001 : clk_div} * {12'h000, (frac_mod == 12'h000) ? 12'h001 : frac_mod})) else $error("sync interval wrong");
   a_sync_only_on: assert property (sync_pulse_o |-> $past(resync_on)) else $error("sync while disabled");
   a_first_ignored: assert property (s_first_sync |=> !phase_realign_o) else $error("realign on first sync");
   a_second_realign: assert property (s_second_sync |=> phase_realign_o) else $error("no realign on second sync");
   a_realign_cause: assert property (phase_realign_o |-> $past(sync_evt) && $past(h_syncs) == 2'h1) else $error("stray realign");
   a_restart_clear: assert property (freq_commit && resync_on && (clk_div > 12'h001 || frac_mod > 12'h001) |=> !sync_evt [*2]) else $error("timer not restarted");
   a_phase_seed: assert property (##1 sdm_seed_o == ($past(ctrl_reg[2][29]) ? 12'h000 : phase_word_o)) else $error("seed wrong");
   a_power_field: assert property (##1 out_power_o == $past(ctrl_reg[4][4:3])) else $error("power field wrong");
   a_fast_lock_len: assert property ($fell(fast_lock_o) && $past(fl_end) |-> $past(h_fl) + 12'h001 == (($past(clk_div) == 12'h000) ? 12'h001 : $past(clk_div))) else $error("fast lock length wrong");
endmodule
